//--- verilog/iev_dispatch.sv
`timescale 1ns/100ps
module iev_dispatch (
	input wire logic clk,
	input wire logic reset,
	input wire logic divide_error_exc,
	input wire logic debug_exc,
	input wire logic nmi_pin,
	input wire logic breakpoint_exc,
	input wire logic overflow_exc,
	input wire logic bound_range_exc,
	input wire logic invalid_opcode_exc,
	input wire logic math_unavailable_exc,
	input wire logic double_fault_exc,
	input wire logic invalid_task_state_exc,
	input wire logic segment_absent_exc,
	input wire logic stack_segment_exc,
	input wire logic general_protection_exc,
	input wire logic page_fault_exc,
	input wire logic math_fault_exc,
	input wire logic alignment_check_exc,
	input wire logic alignment_check_on,
	input wire logic machine_check_exc,
	input wire logic simd_float_exc,
	input wire logic maskable_request_pin,
	input wire logic [7:0] ext_vector,
	input wire logic has_error_code,
	input wire logic [31:0] error_code,
	input wire logic [31:0] flags_in,
	input wire logic [15:0] code_sel_in,
	input wire logic [31:0] instruction_pointer_in,
	input wire logic [31:0] table_base,
	input wire logic handler_done,
	input wire logic gate_wr_en,
	input wire logic [7:0] gate_wr_vec,
	input wire logic [1:0] gate_wr_type,
	input wire logic [15:0] gate_wr_sel,
	input wire logic [31:0] gate_wr_ofs,
	output logic halt_program,
	output logic [7:0] vector,
	output logic [31:0] entry_addr,
	output logic push_valid,
	output logic [31:0] push_data,
	output logic jump_valid,
	output logic [15:0] new_code_sel,
	output logic [31:0] new_instruction_pointer,
	output logic task_call,
	output logic if_flag,
	output logic resume,
	output logic ext_ack
);
	typedef struct packed {
		iev_pkg::iev_state_t st;
		logic nmi_s1;
		logic nmi_s2;
		logic nmi_prev;
		logic irq_s1;
		logic irq_s2;
		logic [7:0] vec_s1;
		logic [7:0] vec_s2;
		logic nmi_pend;
		logic halt_program;
		logic [7:0] vector;
		logic [31:0] entry_addr;
		logic push_valid;
		logic [31:0] push_data;
		logic [2:0] push_idx;
		logic err_pend;
		logic [31:0] err;
		logic [31:0] sv_flags;
		logic [15:0] sv_sel;
		logic [31:0] sv_ip;
		logic is_trap;
		logic jump_valid;
		logic [15:0] new_code_sel;
		logic [31:0] new_instruction_pointer;
		logic task_call;
		logic if_flag;
		logic resume;
		logic ext_ack;
		logic req;
	} iev_dsp_t;

	iev_dsp_t r, next_r;
	iev_gate_if gif();
	logic [7:0] pick;
	logic any;
	logic use_irq;

	iev_gate_table u_table (
		.clk(clk),
		.reset(reset),
		.wr_en(gate_wr_en),
		.wr_vec(gate_wr_vec),
		.wr_type(gate_wr_type),
		.wr_sel(gate_wr_sel),
		.wr_ofs(gate_wr_ofs),
		.gif(gif)
	);
	assign gif.req = r.req;
	assign gif.vec = r.vector;

	// Fixed priority: faults first, then NMI, then maskable pin
	always_comb begin
		pick = 8'h00;
		any = 1'b1;
		use_irq = 1'b0;
		if (double_fault_exc) begin
			pick = iev_pkg::VEC_DOUBLE_FAULT;
		end else if (machine_check_exc) begin
			pick = iev_pkg::VEC_MACHINE;
		end else if (divide_error_exc) begin
			pick = iev_pkg::VEC_DIVIDE;
		end else if (debug_exc) begin
			pick = iev_pkg::VEC_DEBUG;
		end else if (breakpoint_exc) begin
			pick = iev_pkg::VEC_BREAKPOINT;
		end else if (overflow_exc) begin
			pick = iev_pkg::VEC_OVERFLOW;
		end else if (bound_range_exc) begin
			pick = iev_pkg::VEC_BOUND;
		end else if (invalid_opcode_exc) begin
			pick = iev_pkg::VEC_INVALID_OP;
		end else if (math_unavailable_exc) begin
			pick = iev_pkg::VEC_MATH_UNAVAIL;
		end else if (invalid_task_state_exc) begin
			pick = iev_pkg::VEC_TASK_STATE;
		end else if (segment_absent_exc) begin
			pick = iev_pkg::VEC_SEG_ABSENT;
		end else if (stack_segment_exc) begin
			pick = iev_pkg::VEC_STACK_SEG;
		end else if (general_protection_exc) begin
			pick = iev_pkg::VEC_GEN_PROT;
		end else if (page_fault_exc) begin
			pick = iev_pkg::VEC_PAGE_FAULT;
		end else if (math_fault_exc) begin
			pick = iev_pkg::VEC_MATH_FAULT;
		end else if (alignment_check_exc && alignment_check_on) begin
			pick = iev_pkg::VEC_ALIGN;
		end else if (simd_float_exc) begin
			pick = iev_pkg::VEC_SIMD;
		end else if (r.nmi_pend) begin
			pick = iev_pkg::VEC_NMI;
		// Out-of-range external vectors are ignored, never dispatched
		end else if (r.irq_s2 && r.if_flag &&
			r.vec_s2 >= iev_pkg::VEC_USER_MIN) begin
			pick = r.vec_s2;
			use_irq = 1'b1;
		end else begin
			any = 1'b0;
		end
	end

	always_comb begin
		next_r = r;
		next_r.nmi_s1 = nmi_pin;
		next_r.nmi_s2 = r.nmi_s1;
		next_r.nmi_prev = r.nmi_s2;
		next_r.irq_s1 = maskable_request_pin;
		next_r.irq_s2 = r.irq_s1;
		// Vector takes the same two stages as its pin,
		// so a vector changing as the pin drops never pairs
		next_r.vec_s1 = ext_vector;
		next_r.vec_s2 = r.vec_s1;

		// Edge set wins over the clear on acceptance
		if (r.nmi_s2 && !r.nmi_prev) begin
			next_r.nmi_pend = 1'b1;
		end
		next_r.push_valid = 1'b0;
		next_r.jump_valid = 1'b0;
		next_r.resume = 1'b0;
		next_r.ext_ack = 1'b0;
		next_r.req = 1'b0;

		case (r.st)
			iev_pkg::IEV_IDLE: begin
				if (any) begin
					next_r.halt_program = 1'b1;
					next_r.vector = pick;
					next_r.entry_addr = table_base +
						{21'h0, pick, 3'h0};
					next_r.err_pend = has_error_code;
					next_r.err = error_code;
					next_r.sv_flags = flags_in;
					next_r.sv_sel = code_sel_in;
					next_r.sv_ip = instruction_pointer_in;
					next_r.req = 1'b1;
					next_r.ext_ack = use_irq;
					if (pick == iev_pkg::VEC_NMI && !use_irq) begin
						next_r.nmi_pend = r.nmi_s2 && !r.nmi_prev;
					end
					next_r.st = iev_pkg::IEV_FETCH;
				end
			end
			// Table answers a cycle after its request;
			// unused type code acts as an interrupt gate
			iev_pkg::IEV_FETCH: begin
				if (gif.ack) begin
					next_r.new_code_sel = gif.sel;
					next_r.new_instruction_pointer = gif.ofs;
					next_r.is_trap = gif.gate_type == iev_pkg::GATE_TRAP;
					next_r.push_idx = 3'h0;
					if (gif.gate_type == iev_pkg::GATE_TASK) begin
						next_r.task_call = 1'b1;
						next_r.st = iev_pkg::IEV_TASK;
					end else begin
						next_r.st = iev_pkg::IEV_PUSH;
					end
				end
			end
			iev_pkg::IEV_PUSH: begin
				next_r.push_valid = 1'b1;
				next_r.push_idx = r.push_idx + 3'h1;
				case (r.push_idx)
					3'h0: begin
						next_r.push_data = r.sv_flags;
					end
					3'h1: begin
						next_r.push_data = {16'h0, r.sv_sel};
					end
					3'h2: begin
						next_r.push_data = r.sv_ip;
					end
					// Error word last, only when one came with the event
					default: begin
						next_r.push_data = r.err;
					end
				endcase
				if ((r.push_idx == 3'(iev_pkg::PUSH_WORDS - 1)
					&& !r.err_pend) ||
					r.push_idx == 3'(iev_pkg::PUSH_WORDS)) begin
					next_r.jump_valid = 1'b1;
					if (!r.is_trap) begin
						next_r.if_flag = 1'b0;
					end
					next_r.st = iev_pkg::IEV_RUN;
				end
			end
			iev_pkg::IEV_RUN: begin
				if (handler_done) begin
					next_r.halt_program = 1'b0;
					next_r.resume = 1'b1;
					next_r.if_flag = r.sv_flags[iev_pkg::IF_BIT];
					next_r.st = iev_pkg::IEV_IDLE;
				end
			end
			// Task return restores the same state and drops the call in the same cycle
			iev_pkg::IEV_TASK: begin
				if (handler_done) begin
					next_r.halt_program = 1'b0;
					next_r.task_call = 1'b0;
					next_r.resume = 1'b1;
					next_r.if_flag = r.sv_flags[iev_pkg::IF_BIT];
					next_r.st = iev_pkg::IEV_IDLE;
				end
			end
			default: next_r.st = iev_pkg::IEV_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
			r.st <= iev_pkg::IEV_IDLE;
		end else begin
			r <= next_r;
		end
	end

	assign halt_program = r.halt_program;
	assign vector = r.vector;
	assign entry_addr = r.entry_addr;
	assign push_valid = r.push_valid;
	assign push_data = r.push_data;
	assign jump_valid = r.jump_valid;
	assign new_code_sel = r.new_code_sel;
	assign new_instruction_pointer = r.new_instruction_pointer;
	assign task_call = r.task_call;
	assign if_flag = r.if_flag;
	assign resume = r.resume;
	assign ext_ack = r.ext_ack;
endmodule

//--- verilog/iev_pkg.sv
package iev_pkg;
	localparam int VEC_W = 8;
	localparam int ADDR_W = 32;
	localparam int SEL_W = 16;
	localparam int OFS_W = 32;
	localparam int NSRC = 19;
	localparam int ENTRY_SHIFT = 3;
	localparam int PUSH_WORDS = 3;
	localparam int IF_BIT = 9;
	localparam logic [VEC_W-1:0] VEC_DIVIDE = 8'h00;
	localparam logic [VEC_W-1:0] VEC_DEBUG = 8'h01;
	localparam logic [VEC_W-1:0] VEC_NMI = 8'h02;
	localparam logic [VEC_W-1:0] VEC_BREAKPOINT = 8'h03;
	localparam logic [VEC_W-1:0] VEC_OVERFLOW = 8'h04;
	localparam logic [VEC_W-1:0] VEC_BOUND = 8'h05;
	localparam logic [VEC_W-1:0] VEC_INVALID_OP = 8'h06;
	localparam logic [VEC_W-1:0] VEC_MATH_UNAVAIL = 8'h07;
	localparam logic [VEC_W-1:0] VEC_DOUBLE_FAULT = 8'h08;
	localparam logic [VEC_W-1:0] VEC_SEG_OVERRUN = 8'h09;
	localparam logic [VEC_W-1:0] VEC_TASK_STATE = 8'h0A;
	localparam logic [VEC_W-1:0] VEC_SEG_ABSENT = 8'h0B;
	localparam logic [VEC_W-1:0] VEC_STACK_SEG = 8'h0C;
	localparam logic [VEC_W-1:0] VEC_GEN_PROT = 8'h0D;
	localparam logic [VEC_W-1:0] VEC_PAGE_FAULT = 8'h0E;
	localparam logic [VEC_W-1:0] VEC_MATH_FAULT = 8'h10;
	localparam logic [VEC_W-1:0] VEC_ALIGN = 8'h11;
	localparam logic [VEC_W-1:0] VEC_MACHINE = 8'h12;
	localparam logic [VEC_W-1:0] VEC_SIMD = 8'h13;
	localparam logic [VEC_W-1:0] VEC_USER_MIN = 8'h20;
	localparam logic [1:0] GATE_MASKABLE_REQUEST_PIN = 2'h0;
	localparam logic [1:0] GATE_TRAP = 2'h1;
	localparam logic [1:0] GATE_TASK = 2'h2;
	localparam logic [1:0] GATE_NONE = 2'h3;
	typedef enum logic [2:0] {
		IEV_IDLE = 3'h0,
		IEV_FETCH = 3'h1,
		IEV_PUSH = 3'h2,
		IEV_RUN = 3'h3,
		IEV_TASK = 3'h4
	} iev_state_t;
endpackage

//--- verilog/iev_gate_if.sv
`timescale 1ns/100ps
interface iev_gate_if;
	logic req;
	logic [7:0] vec;
	logic ack;
	logic [1:0] gate_type;
	logic [15:0] sel;
	logic [31:0] ofs;
	modport ctl(output req, output vec, input ack, input gate_type,
		input sel, input ofs);
	modport table_side(input req, input vec, output ack, output gate_type,
		output sel, output ofs);
endinterface

//--- verilog/iev_gate_table.sv
`timescale 1ns/100ps
// Small descriptor store, one entry per vector, read data registered
module iev_gate_table (
	input wire logic clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic [7:0] wr_vec,
	input wire logic [1:0] wr_type,
	input wire logic [15:0] wr_sel,
	input wire logic [31:0] wr_ofs,
	iev_gate_if.table_side gif
);
	typedef struct packed {
		logic ack;
		logic [1:0] gate_type;
		logic [15:0] sel;
		logic [31:0] ofs;
	} iev_tbl_t;
	logic [49:0] mem [256];
	iev_tbl_t r, next_r;
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_vec] <= {wr_type, wr_sel, wr_ofs};
		end
	end
	always_comb begin
		next_r = r;
		next_r.ack = gif.req;
		if (gif.req) begin
			{next_r.gate_type, next_r.sel, next_r.ofs} = mem[gif.vec];
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
	assign gif.ack = r.ack;
	assign gif.gate_type = r.gate_type;
	assign gif.sel = r.sel;
	assign gif.ofs = r.ofs;
endmodule

//--- verif/iev_properties.sv
`timescale 1ns/100ps
module iev_properties (
	input wire logic clk,
	input wire logic reset,
	input wire logic divide_error_exc,
	input wire logic double_fault_exc,
	input wire logic machine_check_exc,
	input wire logic [31:0] table_base,
	input wire logic handler_done,
	input wire logic halt_program,
	input wire logic [7:0] vector,
	input wire logic [31:0] entry_addr,
	input wire logic push_valid,
	input wire logic jump_valid,
	input wire logic if_flag,
	input wire logic resume,
	input wire logic ext_ack
);
	logic [2:0] pcnt;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// Pushes since halt rose, cleared between events
	always_ff @(posedge clk) begin
		if (reset || !halt_program) pcnt <= 3'h0;
		else if (push_valid) pcnt <= pcnt + 3'h1;
	end
	AST_ENTRY: assert property ($rose(halt_program) |->
		entry_addr == table_base + {21'h0, vector, 3'h0})
		else $error("entry address wrong");
	AST_RSV: assert property ($rose(halt_program) |->
		!(vector inside {8'h09, 8'h0F, [8'h14:8'h1F]}))
		else $error("reserved vector produced");
	AST_DIV: assert property (!halt_program && !resume &&
		divide_error_exc && !double_fault_exc && !machine_check_exc
		|=> vector == 8'h00)
		else $error("divide error vector wrong");
	AST_DF: assert property (!halt_program && !resume &&
		double_fault_exc |=> halt_program && vector == 8'h08)
		else $error("double fault vector wrong");
	AST_RESUME: assert property (halt_program && handler_done
		|=> resume && !halt_program) else $error("no resume");
	AST_PUSH: assert property (jump_valid |-> push_valid &&
		pcnt inside {3'h2, 3'h3}) else $error("push count wrong");
	AST_IFF: assert property ($fell(if_flag) |-> jump_valid)
		else $error("enable flag cleared outside dispatch");
	AST_ACK: assert property (ext_ack |->
		halt_program && vector >= 8'h20) else $error("pin vector low");
endmodule

//--- verif/iev_partner.sv
`timescale 1ns/100ps
// Pin source and handler stand-in; handler length set by hd_delay
module iev_partner (
	input wire logic clk,
	input wire logic jump_valid,
	input wire logic task_call,
	input wire logic ext_ack,
	input wire logic irq_go,
	input wire logic [7:0] irq_vec,
	input wire logic [3:0] hd_delay,
	output logic handler_done,
	output logic maskable_request_pin,
	output logic [7:0] ext_vector
);
	logic taken = 1'b0;
	logic tc_d = 1'b0;
	logic ack, enter;
	int cnt = 0;
	initial handler_done = 1'b0;
	initial maskable_request_pin = 1'b0;
	initial ext_vector = 8'h00;
	always @(posedge clk) begin
		ack = ext_ack;
		enter = jump_valid || (task_call && !tc_d);
		tc_d = task_call;
		#2;
		handler_done = 1'b0;
		if (enter) cnt = int'(hd_delay) + 1;
		if (cnt == 1) handler_done = 1'b1;
		if (cnt > 0) cnt--;
		if (ack === 1'b1) taken = 1'b1;
		if (!irq_go) taken = 1'b0;
		maskable_request_pin = irq_go && !taken;
		// Released vector lines show the inverse, not the old value
		ext_vector = maskable_request_pin ? irq_vec : ~irq_vec;
	end
endmodule

//--- verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	localparam logic [31:0] BASE = 32'h00012340;
	localparam logic [31:0] FLAGS = 32'h00000202;
	localparam logic [15:0] CSEL = 16'h0008;
	localparam logic [31:0] IP = 32'h00401000;
	localparam logic [7:0] EXP [18] = '{8'h00, 8'h01, 8'h02, 8'h03,
		8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0A, 8'h0B, 8'h0C,
		8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12, 8'h13};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic ac_on = 1'b1, he = 1'b0, gwe = 1'b0, irq_go = 1'b0, ifm = 1'b0;
	logic [17:0] exc = 18'h0;
	logic [7:0] gvec = 8'h00, irq_vec = 8'h00;
	logic [3:0] hd_delay = 4'h0;
	logic [31:0] err = 32'h0;
	logic halt_program, push_valid, jump_valid, task_call, if_flag, resume;
	logic ext_ack, handler_done, maskable_request_pin;
	logic [7:0] vector, ext_vector;
	logic [31:0] entry_addr, push_data, new_ip;
	logic [15:0] new_sel;
	int n_mismatch = 0, compares = 0;
	initial forever #2.5 clk = ~clk;
	// Odd vectors except 0x0D use trap gates and push an error code; 0x0D uses a task gate
	function automatic logic [1:0] gt(input logic [7:0] v);
		return v == 8'h0D ? iev_pkg::GATE_TASK : {1'b0, v[0]};
	endfunction
	iev_dispatch u_dut(.clk, .reset, .divide_error_exc(exc[0]),
		.debug_exc(exc[1]), .nmi_pin(exc[2]), .breakpoint_exc(exc[3]),
		.overflow_exc(exc[4]), .bound_range_exc(exc[5]),
		.invalid_opcode_exc(exc[6]), .math_unavailable_exc(exc[7]),
		.double_fault_exc(exc[8]), .invalid_task_state_exc(exc[9]),
		.segment_absent_exc(exc[10]), .stack_segment_exc(exc[11]),
		.general_protection_exc(exc[12]), .page_fault_exc(exc[13]),
		.math_fault_exc(exc[14]), .alignment_check_exc(exc[15]),
		.alignment_check_on(ac_on), .machine_check_exc(exc[16]),
		.simd_float_exc(exc[17]), .maskable_request_pin, .ext_vector,
		.has_error_code(he), .error_code(err), .flags_in(FLAGS),
		.code_sel_in(CSEL), .instruction_pointer_in(IP), .table_base(BASE),
		.handler_done, .gate_wr_en(gwe), .gate_wr_vec(gvec),
		.gate_wr_type(gt(gvec)), .gate_wr_sel({8'hC0, gvec}),
		.gate_wr_ofs({24'h00F000, gvec}), .halt_program, .vector,
		.entry_addr, .push_valid, .push_data, .jump_valid,
		.new_code_sel(new_sel), .new_instruction_pointer(new_ip),
		.task_call, .if_flag, .resume, .ext_ack);
	iev_partner u_src(.clk, .jump_valid, .task_call, .ext_ack, .irq_go,
		.irq_vec, .hd_delay, .handler_done, .maskable_request_pin,
		.ext_vector);
	task automatic tick;
		@(posedge clk);
		#1;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic give_verdict;
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Empty mask means a pin request carrying ev
	task automatic fire(input logic [17:0] m, input logic [7:0] ev,
		input logic take);
		logic [31:0] pw [4];
		logic [31:0] jo;
		logic [15:0] js;
		logic tk, jv;
		int np, k;
		np = 0;
		tk = 1'b0;
		jv = 1'b0;
		he = ev[0];
		err = {24'hE0C000, ev};
		exc = m;
		irq_vec = ev;
		irq_go = (m == 18'h0);
		for (k = 0; k < 20 && halt_program !== 1'b1; k++) tick;
		exc = 18'h0;
		irq_go = 1'b0;
		if (!take) repeat (6) tick;
		chk(halt_program, take);
		if (take && halt_program !== 1'b1) give_verdict;
		if (halt_program !== 1'b1) return;
		chk(vector, ev);
		chk(ext_ack, m == 18'h0);
		chk(entry_addr, BASE + {21'h0, ev, 3'h0});
		for (k = 0; k < 60 && resume !== 1'b1; k++) begin
			if (push_valid === 1'b1 && np < 4) begin
				pw[np] = push_data;
				np++;
			end
			if (jump_valid === 1'b1) begin
				jv = 1'b1;
				js = new_sel;
				jo = new_ip;
				chk(if_flag, gt(ev) == 2'h0 ? 1'b0 : ifm);
			end
			if (task_call === 1'b1) tk = 1'b1;
			tick;
		end
		chk(resume, 1'b1);
		if (resume !== 1'b1) give_verdict;
		chk(if_flag, FLAGS[9]);
		ifm = FLAGS[9];
		if (gt(ev) == iev_pkg::GATE_TASK) begin
			chk(tk, 1'b1);
			chk(np, 0);
		end else begin
			chk(jv, 1'b1);
			chk(js, {8'hC0, ev});
			chk(jo, {24'h00F000, ev});
			chk(np, 3 + he);
			chk(pw[0], FLAGS);
			chk(pw[1], {16'h0, CSEL});
			chk(pw[2], IP);
			if (he) chk(pw[3], err);
		end
		tick;
	endtask
	task automatic load_gates;
		gwe = 1'b1;
		for (int v = 0; v < 256; v++) begin
			gvec = 8'(v);
			tick;
		end
		gwe = 1'b0;
	endtask
	task automatic s_pin_blocked;
		fire(18'h0, 8'h40, 1'b0);
	endtask
	task automatic s_all_vectors;
		for (int i = 0; i < 18; i++) begin
			hd_delay = 4'(i % 3 * 3);
			fire(18'h1 << i, EXP[i], 1'b1);
		end
	endtask
	task automatic s_prio_align;
		fire(18'h00101, 8'h08, 1'b1);
		fire(18'h10001, 8'h12, 1'b1);
		ac_on = 1'b0;
		fire(18'h08000, 8'h11, 1'b0);
		ac_on = 1'b1;
	endtask
	task automatic s_pin;
		fire(18'h0, 8'h20, 1'b1);
		fire(18'h0, 8'hFF, 1'b1);
		fire(18'h0, 8'h1F, 1'b0);
	endtask
	initial begin
		repeat (5) tick;
		reset = 1'b0;
		chk({halt_program, push_valid, jump_valid, if_flag}, 4'h0);
		load_gates;
		s_pin_blocked;
		s_all_vectors;
		s_prio_align;
		s_pin;
		give_verdict;
	end
endmodule
bind iev_dispatch iev_properties u_chk(.clk, .reset, .divide_error_exc,
	.double_fault_exc, .machine_check_exc, .table_base, .handler_done,
	.halt_program, .vector, .entry_addr, .push_valid, .jump_valid,
	.if_flag, .resume, .ext_ack);
